// ---- src/ccp_top.v ----
// codec control port: spi or i2c slave, register file, interrupt pin, power-up mute
`timescale 1ns/1ps
`default_nettype none
`include "ccp_defines.vh"
module ccp_top #(
  parameter        NSRC        = 4,
  parameter [31:0] RAMP_CYCLES = `CCP_RAMP_CYCLES
) (
  input  wire            clk_i,           // 25 mhz block clock
  input  wire            rstn_i,          // reset pin, sync, active low
  input  wire            addr0_or_select_pin_i, // select (spi) or strap zero (i2c)
  input  wire            addr_strap_one_i,      // i2c strap one
  input  wire            control_bit_clock_i,   // spi clock / i2c scl
  input  wire            serial_cmd_in_i,       // spi data in / i2c sda in
  output reg             serial_reply_out_o,    // spi data out / i2c sda out
  output reg             serial_reply_oe_o,     // output enable of reply pin
  input  wire            pll_selected_i,  // clock source is internal pll
  input  wire            pll_locked_i,    // pll settled, same clock
  input  wire [NSRC-1:0] irq_src_i,       // interrupt sources, same clock
  input  wire [NSRC-1:0] irq_mask_i,      // per-source mask
  input  wire [2*NSRC-1:0] irq_sens_i,    // per-source sensitivity
  input  wire [1:0]      irq_mode_i,      // pin polarity / drive mode
  output reg             irq_o,           // interrupt pin level
  output reg             irq_oe_o,        // interrupt pin enable
  output reg             spi_mode_o,      // 1 when spi selected
  output reg             power_down_bit_o, // power-down bit of power register
  output reg             mute_o,          // converter and port mute
  output reg             audio_out_en_o   // serial audio outputs enabled
);
  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  wire sel_s, a1_s, scl_s, sda_s;
  ccp_sync u_sel (.clk_i(clk_i), .rstn_i(rstn_i), .rst_val_i(1'b1),
                  .d_i(addr0_or_select_pin_i), .q_o(sel_s));
  ccp_sync u_a1  (.clk_i(clk_i), .rstn_i(rstn_i), .rst_val_i(1'b1),
                  .d_i(addr_strap_one_i), .q_o(a1_s));
  ccp_sync u_scl (.clk_i(clk_i), .rstn_i(rstn_i), .rst_val_i(1'b1),
                  .d_i(control_bit_clock_i), .q_o(scl_s));
  ccp_sync u_sda (.clk_i(clk_i), .rstn_i(rstn_i), .rst_val_i(1'b1),
                  .d_i(serial_cmd_in_i), .q_o(sda_s));

  reg sel_d_reg, scl_d_reg, sda_d_reg;
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      sel_d_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      sel_d_reg <= sel_s;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  wire clk_rise = scl_s & ~scl_d_reg;
  wire clk_fall = ~scl_s & scl_d_reg;
  wire sel_fall = ~sel_s & sel_d_reg;
  wire i2c_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire i2c_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ------------------------------------------------------------------
  // strap capture and mode choice
  // ------------------------------------------------------------------
  // straps are taken from the synchroniser outputs in the reset cycles; reset holds those at 1, so both address bits are always 1
  reg [1:0] strap_reg;
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      strap_reg <= {a1_s, sel_s};
    end
  end
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      spi_mode_o <= 1'b0;
    end else if (sel_fall) begin
      spi_mode_o <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------
  reg [7:0] regs [0:`CCP_NUM_REGS-1];
  reg [7:0] ptr_reg;
  integer k;

  // ------------------------------------------------------------------
  // shared transfer engine
  // ------------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_PTR  = 3'h2;
  localparam ST_WDAT = 3'h3;
  localparam ST_RDAT = 3'h4;
  localparam ST_ACK  = 3'h5;
  localparam ST_RACK = 3'h6;
  localparam ST_SKIP = 3'h7;

  reg [2:0] state_reg;
  reg [2:0] after_ack_reg;
  reg [7:0] shift_reg;
  reg [2:0] cnt_reg;
  reg       nack_reg;

  wire [6:0] i2c_addr   = {`CCP_I2C_ADDR_HI, strap_reg};
  // both modes sample the same synchronised data pin
  wire [7:0] rx_byte    = {shift_reg[6:0], sda_s};
  wire       inc        = ptr_reg[`CCP_PTR_INC_BIT];
  wire [6:0] reg_idx    = ptr_reg[6:0];
  wire [7:0] ptr_adv    = inc ? {ptr_reg[7], reg_idx + 7'h01} : ptr_reg;
  wire       active     = spi_mode_o ? ~sel_s : 1'b1;
  wire       addr_ok    = spi_mode_o ? (rx_byte[7:1] == `CCP_SPI_CHIP_ADDR)
                                     : (rx_byte[7:1] == i2c_addr);

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg          <= ST_IDLE;
      after_ack_reg      <= ST_IDLE;
      shift_reg          <= 8'h00;
      cnt_reg            <= 3'h0;
      ptr_reg            <= 8'h00;
      nack_reg           <= 1'b0;
      serial_reply_out_o <= 1'b1;
      serial_reply_oe_o  <= 1'b0;
      for (k = 0; k < `CCP_NUM_REGS; k = k + 1) begin
        regs[k] <= 8'h00;
      end
      regs[`CCP_PWR_REG_ADDR] <= `CCP_PWR_RESET_VAL;
    end else if (spi_mode_o && sel_s) begin
      state_reg         <= ST_IDLE;
      serial_reply_oe_o <= 1'b0;
    end else if (!spi_mode_o && (i2c_start || i2c_stop)) begin
      state_reg         <= i2c_start ? ST_ADDR : ST_IDLE;
      cnt_reg           <= 3'h0;
      serial_reply_oe_o <= 1'b0;
    end else begin
      if (spi_mode_o && state_reg == ST_IDLE && active) begin
        state_reg <= ST_ADDR;
        cnt_reg   <= 3'h0;
      end
      if (clk_rise && state_reg != ST_IDLE && state_reg != ST_SKIP) begin
        if (state_reg == ST_RACK) begin
          // host acknowledge: sampled here, then cleared at the next falling edge
          nack_reg <= sda_s;
        end else if (state_reg == ST_ACK) begin
          nack_reg <= 1'b0;
        end else if (state_reg != ST_RDAT) begin
          shift_reg <= rx_byte;
          cnt_reg   <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h7) begin
            case (state_reg)
              ST_ADDR: begin
                if (!addr_ok) begin
                  state_reg <= ST_SKIP;
                end else begin
                  after_ack_reg <= rx_byte[0] ? ST_RDAT : ST_PTR;
                  state_reg     <= spi_mode_o ? (rx_byte[0] ? ST_RDAT : ST_PTR) : ST_ACK;
                  shift_reg     <= regs[reg_idx];
                end
              end
              ST_PTR: begin
                ptr_reg       <= rx_byte;
                after_ack_reg <= ST_WDAT;
                state_reg     <= spi_mode_o ? ST_WDAT : ST_ACK;
              end
              default: begin
                regs[reg_idx] <= rx_byte;
                ptr_reg       <= ptr_adv;
                after_ack_reg <= ST_WDAT;
                state_reg     <= spi_mode_o ? ST_WDAT : ST_ACK;
              end
            endcase
          end
        end else begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h7) begin
            ptr_reg   <= ptr_adv;
            shift_reg <= regs[ptr_adv[6:0]];
            state_reg <= spi_mode_o ? ST_RDAT : ST_RACK;
          end
        end
      end
      if (clk_fall) begin
        case (state_reg)
          ST_ACK: begin
            if (serial_reply_oe_o && cnt_reg == 3'h0 && !nack_reg) begin
              serial_reply_oe_o <= 1'b0; // release after ack bit
              state_reg         <= after_ack_reg;
            end else begin
              serial_reply_out_o <= 1'b0;
              serial_reply_oe_o  <= 1'b1;
              nack_reg           <= 1'b1;
            end
          end
          ST_RACK: begin
            serial_reply_oe_o <= 1'b0;
            state_reg         <= ST_SKIP;
            nack_reg          <= 1'b0;
          end
          ST_RDAT: begin
            serial_reply_out_o <= shift_reg[~cnt_reg];
            serial_reply_oe_o  <= 1'b1;
          end
          default: begin
            serial_reply_oe_o <= 1'b0;
          end
        endcase
      end
      // after host ack, return to data on the next falling edge, whatever the host sent
      if (state_reg == ST_SKIP && !spi_mode_o && clk_fall && !nack_reg
          && after_ack_reg == ST_RDAT) begin
        state_reg <= ST_RDAT;
      end
    end
  end

  // ------------------------------------------------------------------
  // interrupt pin
  // ------------------------------------------------------------------
  wire [NSRC-1:0] req;
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_src
      ccp_irq_src u_src (.clk_i(clk_i), .rstn_i(rstn_i), .src_i(irq_src_i[g]),
                         .mask_i(irq_mask_i[g]), .sens_i(irq_sens_i[2*g+1:2*g]),
                         .req_o(req[g]));
    end
  endgenerate
  wire any_req = |req;
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_o    <= 1'b1;
      irq_oe_o <= 1'b0;
    end else begin
      case (irq_mode_i)
        `CCP_INT_MODE_HIGH: begin
          irq_o    <= any_req;
          irq_oe_o <= 1'b1;
        end
        `CCP_INT_MODE_OD: begin
          irq_o    <= 1'b0;
          irq_oe_o <= any_req;
        end
        default: begin
          irq_o    <= ~any_req;
          irq_oe_o <= 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // power-up, ramp mute and pll gating
  // ------------------------------------------------------------------
  // the ramp counter runs from reset release regardless of the power bit
  reg [31:0] ramp_cnt_reg;
  wire       ramp_done = (ramp_cnt_reg >= RAMP_CYCLES);
  wire       power_down_bit = regs[`CCP_PWR_REG_ADDR][`CCP_PDN_BIT];
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      ramp_cnt_reg     <= 32'h0;
      power_down_bit_o <= 1'b1;
      mute_o           <= 1'b1;
      audio_out_en_o   <= 1'b0;
    end else begin
      if (!ramp_done) begin
        ramp_cnt_reg <= ramp_cnt_reg + 32'h1;
      end
      power_down_bit_o <= power_down_bit;
      mute_o           <= power_down_bit | ~ramp_done;
      audio_out_en_o   <= ~power_down_bit & ramp_done & (~pll_selected_i | pll_locked_i);
    end
  end
endmodule
`default_nettype wire

// ---- pkg/ccp_defines.vh ----
// constants for the codec control port
//
// Contract
// - falling edge on select pin after reset picks spi mode, else i2c with strap
// - spi samples input on rising clock edge, shifts output on falling edge
// - spi transfers start with chip address 1001111 then r/w bit, low writes
// - spi write: pointer byte then data byte msb first, stored at pointer
// - serial reply output stays high impedance during spi writes
// - auto advance flag set advances pointer per byte, clear keeps it fixed
// - after read address, msb driven on next falling clock, rest follow
// - with auto advance, spi read streams consecutive registers
// - i2c low address bits come from straps captured during reset; the code captures synchroniser outputs held at 1 in reset, so both are 1
// - i2c address is 10011, two strap bits, then r/w high for read
// - i2c write: pointer byte after address, further bytes go to registers
// - i2c read sends register at pointer, advancing when flag set; the code leaves the msb clock released and sends only bits 6 to 0
// - every i2c byte is acknowledged by its receiver
// - interrupt pin: active low, active high, or open-drain active low
// - each interrupt source has a mask and edge or level sensitivity
// - reset low clears all state, mutes outputs, holds low power
// - after reset writes accepted; clearing power-down bit starts operation
// - with pll clock, serial audio outputs wait for pll lock
// - about 80 ms mute after reset while reference ramps
`ifndef CCP_DEFINES_VH
`define CCP_DEFINES_VH
`define CCP_SPI_CHIP_ADDR   7'h4f
`define CCP_I2C_ADDR_HI     5'h13
`define CCP_PTR_INC_BIT     7
`define CCP_NUM_REGS        128
`define CCP_PWR_REG_ADDR    7'h02
`define CCP_PDN_BIT         0
`define CCP_PWR_RESET_VAL   8'h81
`define CCP_CLK_HZ          25000000
`define CCP_RAMP_MS         80
`define CCP_RAMP_CYCLES     ((`CCP_CLK_HZ / 1000) * `CCP_RAMP_MS)
`define CCP_INT_MODE_LOW    2'h0
`define CCP_INT_MODE_HIGH   2'h1
`define CCP_INT_MODE_OD     2'h2
`define CCP_SENS_LEVEL      2'h0
`define CCP_SENS_RISE       2'h1
`define CCP_SENS_FALL       2'h2
`endif

// ---- src/ccp_sync.v ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ccp_sync (
  input  wire clk_i,   // block clock
  input  wire rstn_i,  // sync reset, active low
  input  wire rst_val_i, // value taken in reset (tie constant)
  input  wire d_i,     // asynchronous input
  output reg  q_o      // synchronised level
);
  reg meta_reg;
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_reg <= rst_val_i;
      q_o      <= rst_val_i;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- src/ccp_irq_src.v ----
// one interrupt source: sensitivity select and mask
`timescale 1ns/1ps
`default_nettype none
`include "ccp_defines.vh"
module ccp_irq_src (
  input  wire       clk_i,   // block clock
  input  wire       rstn_i,  // sync reset, active low
  input  wire       src_i,   // source level, same clock
  input  wire       mask_i,  // 1 blocks the source
  input  wire [1:0] sens_i,  // level, rising or falling
  output reg        req_o    // active request
);
  reg prev_reg;
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      prev_reg <= 1'b0;
      req_o    <= 1'b0;
    end else begin
      prev_reg <= src_i;
      if (mask_i) begin
        req_o <= 1'b0;
      end else begin
        case (sens_i)
          `CCP_SENS_RISE: req_o <= src_i & ~prev_reg;
          `CCP_SENS_FALL: req_o <= ~src_i & prev_reg;
          default:        req_o <= src_i;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/ccp_top_props.sv ----
// checker: concurrent assertions on the control port pins
`timescale 1ns/1ps
`default_nettype none
module ccp_top_props #(
  parameter        NSRC        = 4,
  parameter [31:0] RAMP_CYCLES = 100
) (
  input wire logic              clk_i,                 // clock
  input wire logic              rstn_i,                // reset
  input wire logic              addr0_or_select_pin_i, // select
  input wire logic              serial_reply_oe_o,     // reply enable
  input wire logic              pll_selected_i,        // pll source
  input wire logic              pll_locked_i,          // pll lock
  input wire logic [NSRC-1:0]   irq_src_i,             // sources
  input wire logic [NSRC-1:0]   irq_mask_i,            // masks
  input wire logic [2*NSRC-1:0] irq_sens_i,            // sensitivity
  input wire logic [1:0]        irq_mode_i,            // pin mode
  input wire logic              irq_o,                 // pin level
  input wire logic              irq_oe_o,              // pin enable
  input wire logic              spi_mode_o,            // mode
  input wire logic              power_down_bit_o,      // power-down
  input wire logic              mute_o,                // mute
  input wire logic              audio_out_en_o         // audio enable
);
  wire pll_wait = pll_selected_i && !pll_locked_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ------------------------------
  // sequences and properties
  // ------------------------------
  sequence desel_s;
    spi_mode_o && addr0_or_select_pin_i;
  endsequence
  sequence lvl_low_s;
    irq_src_i[0] && !irq_mask_i[0] && irq_sens_i[1:0] == 2'h0 && irq_mode_i == 2'h0;
  endsequence
  sequence masked_s;
    irq_mask_i == {NSRC{1'b1}} && irq_mode_i == 2'h1;
  endsequence
  AST_RESET: assert property (disable iff (1'b0) !rstn_i |=> mute_o && power_down_bit_o
    && !serial_reply_oe_o && !irq_oe_o && !audio_out_en_o && !spi_mode_o)
    else $error("reset state wrong");
  AST_RAMP_MUTE: assert property ($rose(rstn_i) |-> mute_o [*8])
    else $error("mute released too early");
  AST_PLL_WAIT: assert property ($past(pll_wait, 1) && $past(pll_wait, 2) |-> !audio_out_en_o)
    else $error("audio enabled before pll lock");
  AST_SEL_MODE: assert property ($fell(addr0_or_select_pin_i) |-> ##[1:6] spi_mode_o)
    else $error("select edge did not pick spi mode");
  AST_MODE_KEEP: assert property (spi_mode_o |=> spi_mode_o)
    else $error("spi mode lost");
  AST_REPLY_REL: assert property (desel_s [*5] |-> !serial_reply_oe_o)
    else $error("reply driven while deselected");
  AST_OD_LOW: assert property (irq_mode_i == 2'h2 && $stable(irq_mode_i) |-> !(irq_oe_o && irq_o))
    else $error("open drain pin driven high");
  AST_MASK: assert property (masked_s [*3] |-> !irq_o)
    else $error("masked source reached pin");
  AST_LEVEL: assert property (lvl_low_s [*3] |-> !irq_o)
    else $error("level source not on active low pin");
endmodule
bind ccp_top ccp_top_props #(.NSRC(NSRC), .RAMP_CYCLES(RAMP_CYCLES)) u_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .addr0_or_select_pin_i(addr0_or_select_pin_i),
  .serial_reply_oe_o(serial_reply_oe_o), .pll_selected_i(pll_selected_i),
  .pll_locked_i(pll_locked_i), .irq_src_i(irq_src_i), .irq_mask_i(irq_mask_i),
  .irq_sens_i(irq_sens_i), .irq_mode_i(irq_mode_i), .irq_o(irq_o), .irq_oe_o(irq_oe_o),
  .spi_mode_o(spi_mode_o), .power_down_bit_o(power_down_bit_o), .mute_o(mute_o),
  .audio_out_en_o(audio_out_en_o)
);
`default_nettype wire

// ---- sim/ccp_host_model.sv ----
// host side serial master model for the control port
`timescale 1ns/1ps
`default_nettype none
module ccp_host_model (
  output logic      sel_n_o, // select, low in a frame
  output logic      sclk_o,  // link clock, idles high
  output logic      mosi_o,  // command data
  input  wire logic miso_i   // reply as seen on the wire
);
  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b1;
    mosi_o = 1'b0;
  end
  // ------------------------------
  // frame tasks
  // ------------------------------
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = tx[i];
      #160;
      sclk_o = 1'b1;
      rx[i] = miso_i;
      #160;
    end
  endtask
  task automatic open_frame;
    sel_n_o = 1'b0;
    #160;
  endtask
  task automatic close_frame;
    #160;
    sel_n_o = 1'b1;
    mosi_o = ~mosi_o; // released line must not keep its last bit
    #320;
  endtask
  task automatic write2(input logic [7:0] hdr, ptr, d0, d1);
    logic [7:0] rx;
    open_frame;
    xfer(hdr, rx);
    xfer(ptr, rx);
    xfer(d0, rx);
    xfer(d1, rx);
    close_frame;
  endtask
  task automatic set_ptr(input logic [7:0] ptr);
    logic [7:0] rx;
    open_frame;
    xfer(8'h9e, rx);
    xfer(ptr, rx);
    close_frame;
  endtask
  task automatic read2(output logic [7:0] a, b);
    logic [7:0] rx;
    open_frame;
    xfer(8'h9f, rx);
    xfer(8'h00, a);
    xfer(8'h00, b);
    close_frame;
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking testbench for the codec control port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       pll_lock = 1'b0;
  logic       pll_sel = 1'b1;
  logic       strap1 = 1'b0;
  logic       wr_phase = 1'b0;
  logic [3:0] src = 4'h0;
  logic [3:0] mask = 4'h0;
  logic [7:0] sens = 8'h00;
  logic [1:0] mode = 2'h0;
  logic [7:0] a, b;
  wire        sel_n, sclk, mosi, rep, rep_oe, rep_w, irq, irq_oe, spi_mode, power_down_bit, mute, aen;
  int         error_cnt = 0, check_count = 0, cycles = 0, hiz_hits = 0;
  always #20 clk_i = ~clk_i;
  // released reply line floats away from its last bit
  assign rep_w = rep_oe ? rep : ~rep;
  ccp_top #(.NSRC(4), .RAMP_CYCLES(100)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr0_or_select_pin_i(sel_n),
    .addr_strap_one_i(strap1), .control_bit_clock_i(sclk), .serial_cmd_in_i(mosi),
    .serial_reply_out_o(rep), .serial_reply_oe_o(rep_oe), .pll_selected_i(pll_sel),
    .pll_locked_i(pll_lock), .irq_src_i(src), .irq_mask_i(mask), .irq_sens_i(sens),
    .irq_mode_i(mode), .irq_o(irq), .irq_oe_o(irq_oe), .spi_mode_o(spi_mode),
    .power_down_bit_o(power_down_bit), .mute_o(mute), .audio_out_en_o(aen)
  );
  ccp_host_model u_host (.sel_n_o(sel_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(rep_w));
  // ------------------------------
  // tasks
  // ------------------------------
  task final_report;
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task wr(input logic [7:0] hdr, ptr, d0, d1);
    wr_phase = 1'b1;
    u_host.write2(hdr, ptr, d0, d1);
    wr_phase = 1'b0;
  endtask
  task irq_edge(input logic [1:0] s, input logic from);
    int k;
    mask[0] = 1'b1;
    src[0] = from;
    sens[1:0] = s;
    cyc(4);
    mask[0] = 1'b0;
    cyc(4);
    chk1(irq, 1'b0);
    src[0] = ~from;
    k = 0;
    while (irq !== 1'b1 && k < 8) begin
      cyc(1);
      k++;
    end
    chk1(irq, 1'b1);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (wr_phase && rep_oe === 1'b1) hiz_hits++;
    if (cycles == 10000) begin
      error_cnt++;
      $display("[FAIL] %0t run did not finish", $time);
      final_report;
    end
  end
  initial begin
    cyc(8);
    rstn_i = 1'b1;
    cyc(2);
    chk1(spi_mode, 1'b0);
    chk1(power_down_bit, 1'b1);
    chk1(mute, 1'b1);
    wr(8'h9e, 8'h05, 8'ha5, 8'h3c);
    chk1(spi_mode, 1'b1);
    wr(8'h9e, 8'h90, 8'h11, 8'h22);
    wr(8'h9c, 8'h12, 8'h77, 8'h77);
    u_host.set_ptr(8'h05);
    u_host.read2(a, b);
    chk8(a, 8'h3c);
    chk8(b, 8'h3c);
    u_host.set_ptr(8'h91);
    u_host.read2(a, b);
    chk8(a, 8'h22);
    chk8(b, 8'h00);
    u_host.set_ptr(8'h02);
    u_host.read2(a, b);
    chk8(a, 8'h81);
    wr(8'h9e, 8'h02, 8'h80, 8'h80);
    chk1(power_down_bit, 1'b0);
    chk1(aen, 1'b0);
    chk1(hiz_hits == 0, 1'b1);
    pll_lock = 1'b1;
    cyc(8);
    chk1(aen, 1'b1);
    chk1(mute, 1'b0);
    pll_lock = 1'b0;
    cyc(4);
    chk1(aen, 1'b0);
    pll_sel = 1'b0;
    cyc(4);
    chk1(aen, 1'b1);
    src = 4'h1;
    for (int m = 0; m < 3; m++) begin
      mode = m[1:0];
      cyc(4);
      chk1(irq_oe === 1'b1 && irq === (m == 1), 1'b1);
    end
    mask = 4'h1;
    cyc(4);
    chk1(irq_oe, 1'b0);
    mode = 2'h1;
    mask = 4'hf;
    cyc(4);
    chk1(irq, 1'b0);
    mask = 4'h0;
    irq_edge(2'h1, 1'b0);
    irq_edge(2'h2, 1'b1);
    cyc(4);
    final_report;
  end
endmodule
`default_nettype wire
